// ==== core/uml_core.sv ====
// multidrop (9-bit) and LIN extension of an asynchronous serial transceiver
// assumes rxd is already synchronous to pclk and an external LIN transceiver
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module uml_core
	import uml_pkg::*;
#(
	parameter int WAKE_CYCLES = WAKE_CYC
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// serial line
	input  wire logic        rxd,
	output logic             txd
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic                 acc, wr, rd, hit;
	logic [31:0]          st_clr;
	logic [CTRL_W-1:0]    ctrl_r, ctrl_nxt;
	logic [15:0]          baud_r, baud_nxt, match_r, match_nxt, meas_r, meas_nxt;
	logic [8:0]           rxdata_r, rxdata_nxt;
	logic                 rxv_r, rxv_nxt, coll_r, coll_nxt, ferr_r, ferr_nxt;
	logic                 perr_r, perr_nxt, matched_r, matched_nxt;
	logic [31:0]          prdata_r, prdata_nxt;
	logic [31:0]          status, rdmux;
	logic [CNT_W-1:0]     baud_m1;

	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign hit = (paddr[1:0] == 2'b00) && (paddr <= OFF_LIN);
	assign pready = 1'b1;                       // every access completes at once
	assign pslverr = acc & ~hit;
	assign prdata = prdata_r;
	assign st_clr = (wr && paddr == OFF_STATUS) ? pwdata : 32'h0000_0000;
	assign baud_m1 = CNT_W'(baud_r) - CNT_W'(1);

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	uml_tx_e          tx_st_r, tx_st_nxt;
	logic [CNT_W-1:0] tx_cnt_r, tx_cnt_nxt;
	logic [3:0]       tx_bit_r, tx_bit_nxt, tx_lastbit;
	logic [8:0]       tx_fr_r, tx_fr_nxt;
	logic             txd_r, txd_nxt, tx_par, par_on_tx, tx_go, tx_end, tx_mid;

	assign txd = txd_r;
	assign tx_go = wr && paddr == OFF_TXDATA && ctrl_r[CTRL_EN];
	assign tx_end = (tx_cnt_r == baud_m1);
	assign tx_mid = (tx_cnt_r == CNT_W'(baud_r[15:1]));
	assign tx_lastbit = ctrl_r[CTRL_TX9] ? 4'h8 : 4'h7;
	assign par_on_tx = ctrl_r[CTRL_PEN] & ~ctrl_r[CTRL_MD];
	assign tx_par = ^(tx_fr_r & {ctrl_r[CTRL_TX9], 8'hFF}) ^ ctrl_r[CTRL_PODD];

	// next-state for the transmit sequencer; break reuses the bit timer, wake counts WAKE_CYCLES on the same counter
	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_bit_nxt = tx_bit_r;
		tx_fr_nxt = tx_fr_r;
		txd_nxt = txd_r;
		tx_cnt_nxt = (tx_st_r == TX_IDLE || tx_end) ? '0 : tx_cnt_r + CNT_W'(1);
		unique case (tx_st_r)
			TX_IDLE: begin
				if (tx_go && pwdata[TXC_BRK]) begin
					tx_st_nxt = TX_BREAK;
					tx_bit_nxt = 4'h0;
					txd_nxt = 1'b0;
				end else if (tx_go && pwdata[TXC_WAKE]) begin
					tx_st_nxt = TX_WAKE;
					txd_nxt = 1'b0;
				end else if (tx_go) begin
					tx_fr_nxt = pwdata[8:0];
					tx_st_nxt = TX_START;
					txd_nxt = 1'b0;
				end
			end
			TX_START: begin
				if (tx_end) begin
					tx_st_nxt = TX_DATA;
					tx_bit_nxt = 4'h0;
					txd_nxt = tx_fr_r[0];
				end
			end
			TX_DATA: begin
				if (tx_end && tx_bit_r == tx_lastbit) begin
					tx_st_nxt = par_on_tx ? TX_PAR : TX_STOP;
					txd_nxt = par_on_tx ? tx_par : 1'b1;
				end else if (tx_end) begin
					tx_bit_nxt = tx_bit_r + 4'h1;
					txd_nxt = tx_fr_r[tx_bit_r + 4'h1];
				end
			end
			TX_PAR: begin
				if (tx_end) begin
					tx_st_nxt = TX_STOP;
					txd_nxt = 1'b1;
				end
			end
			TX_STOP: begin
				if (tx_end)
					tx_st_nxt = TX_IDLE;
			end
			TX_BREAK: begin
				if (tx_end && tx_bit_r == BREAK_BITS - 4'h1) begin
					tx_st_nxt = TX_DELIM;
					txd_nxt = 1'b1;
				end else if (tx_end) begin
					tx_bit_nxt = tx_bit_r + 4'h1;
				end
			end
			TX_DELIM: begin
				if (tx_end)
					tx_st_nxt = TX_IDLE;
			end
			TX_WAKE: begin
				// wake pulse runs on its own count, not on the bit period
				tx_cnt_nxt = tx_cnt_r + CNT_W'(1);
				if (tx_cnt_r == CNT_W'(WAKE_CYCLES - 1)) begin
					tx_st_nxt = TX_IDLE;
					txd_nxt = 1'b1;
					tx_cnt_nxt = '0;
				end
			end
		endcase
	end

	// transmit registers; line idles high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_r <= TX_IDLE;
			tx_cnt_r <= '0;
			tx_bit_r <= 4'h0;
			tx_fr_r <= 9'h000;
			txd_r <= 1'b1;
		end else begin
			tx_st_r <= tx_st_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_bit_r <= tx_bit_nxt;
			tx_fr_r <= tx_fr_nxt;
			txd_r <= tx_nxt_gate(txd_nxt);
		end
	end

	function automatic logic tx_nxt_gate(input logic v);
		tx_nxt_gate = v;
	endfunction : tx_nxt_gate

	chk_tx_lsb_first: assert property (tx_st_r == TX_DATA |-> txd_r == tx_fr_r[tx_bit_r])
		else $error("transmitted data bit differs from frame bit");
	chk_tx_no_parity: assert property (ctrl_r[CTRL_MD] |-> tx_st_r != TX_PAR)
		else $error("parity bit sent in multidrop mode");
	chk_tx_break_len: assert property ((tx_st_r == TX_BREAK && tx_st_nxt == TX_DELIM)
		|-> tx_bit_r == 4'hC && txd_r == 1'b0) else $error("break not thirteen bits low");
	chk_tx_wake_pulse: assert property ($rose(tx_st_r == TX_WAKE) |->
		!txd_r [*8] ##1 (tx_st_r == TX_WAKE)) else $error("wake pulse ended early");

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	uml_rx_e          rx_st_r, rx_st_nxt;
	logic [CNT_W-1:0] rx_cnt_r, rx_cnt_nxt;
	logic [3:0]       rx_bit_r, rx_bit_nxt, rx_lastbit;
	logic [8:0]       rx_sh_r, rx_sh_nxt;
	logic             rx_pe_r, rx_pe_nxt, rx_done, rx_fe, rx_end, par_on_rx;
	logic             rxd_d_r, fall;

	assign rx_end = (rx_cnt_r == baud_m1);
	assign rx_lastbit = ctrl_r[CTRL_RX9] ? 4'h8 : 4'h7;
	assign par_on_rx = ctrl_r[CTRL_PEN] & ~ctrl_r[CTRL_MD];

	// single mid-bit sample; the start bit is re-checked at its centre
	always_comb begin
		rx_st_nxt = rx_st_r;
		rx_bit_nxt = rx_bit_r;
		rx_sh_nxt = rx_sh_r;
		rx_pe_nxt = rx_pe_r;
		rx_cnt_nxt = rx_end ? '0 : rx_cnt_r + CNT_W'(1);
		rx_done = 1'b0;
		rx_fe = 1'b0;
		unique case (rx_st_r)
			RX_IDLE: begin
				rx_cnt_nxt = '0;
				// start only on a falling edge: a line still low after a
				// break frame must not open a second, misaligned frame
				if (fall && ctrl_r[CTRL_EN])
					rx_st_nxt = RX_START;
			end
			RX_START: begin
				if (rx_cnt_r == CNT_W'(baud_r[15:1])) begin
					rx_st_nxt = rxd ? RX_IDLE : RX_DATA;
					rx_cnt_nxt = '0;
					rx_bit_nxt = 4'h0;
					rx_sh_nxt = 9'h000;
					rx_pe_nxt = ctrl_r[CTRL_PODD];
				end
			end
			RX_DATA: begin
				if (rx_end) begin
					rx_sh_nxt[rx_bit_r] = rxd;
					rx_pe_nxt = rx_pe_r ^ rxd;
					rx_bit_nxt = rx_bit_r + 4'h1;
					if (rx_bit_r == rx_lastbit)
						rx_st_nxt = par_on_rx ? RX_PAR : RX_STOP;
				end
			end
			RX_PAR: begin
				if (rx_end) begin
					rx_pe_nxt = rx_pe_r ^ rxd;
					rx_st_nxt = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rx_end) begin
					rx_done = 1'b1;
					rx_fe = ~rxd;
					rx_st_nxt = RX_IDLE;
				end
			end
			default: rx_st_nxt = RX_IDLE;
		endcase
	end

	// receive registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_r <= RX_IDLE;
			rx_cnt_r <= '0;
			rx_bit_r <= 4'h0;
			rx_sh_r <= 9'h000;
			rx_pe_r <= 1'b0;
		end else begin
			rx_st_r <= rx_st_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_bit_r <= rx_bit_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_pe_r <= rx_pe_nxt;
		end
	end

	// ----------------------------------------------------------------
	// LIN break, sync timing and frame checks
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] low_r, low_nxt, brk_cyc, sy_cnt_r, sy_cnt_nxt;
	logic [2:0]       sy_fall_r, sy_fall_nxt;
	logic [3:0]       idx_r, idx_nxt;
	logic [7:0]       sum_r, sum_nxt, rb;
	logic [8:0]       sum_c;
	logic             sy_wait_r, sy_wait_nxt, sy_on_r, sy_on_nxt, meas_upd;
	logic             brk_hit, p0, p1;
	logic [CNT_W-1:0] sy_span;
	logic [6:0]       lf_r, lf_nxt;   // brk, sync, sleep, pid err, rsv, diag, sleep cand

	assign fall = rxd_d_r & ~rxd;
	// the counter lags the first edge by one cycle, so add it back
	assign sy_span = sy_cnt_r + CNT_W'(1);
	assign brk_cyc = CNT_W'(baud_r) * CNT_W'(BREAK_BITS);
	assign brk_hit = ctrl_r[CTRL_LIN] && !rxd && (low_r == brk_cyc - CNT_W'(1));
	assign rb = rx_sh_r[7:0];
	assign p0 = rb[0] ^ rb[1] ^ rb[2] ^ rb[4];
	assign p1 = ~(rb[1] ^ rb[3] ^ rb[4] ^ rb[5]);
	assign sum_c = {1'b0, sum_r} + {1'b0, rb};

	// break sets up a new frame; sync edges span eight bit periods
	always_comb begin
		low_nxt = rxd ? '0 : (brk_hit ? low_r : low_r + CNT_W'(1));
		sy_wait_nxt = sy_wait_r;
		sy_on_nxt = sy_on_r;
		sy_cnt_nxt = sy_on_r ? sy_cnt_r + CNT_W'(1) : '0;
		sy_fall_nxt = sy_fall_r;
		idx_nxt = idx_r;
		sum_nxt = sum_r;
		meas_upd = 1'b0;
		lf_nxt = lf_r & ~{1'b0, st_clr[ST_DIAG:ST_PIDE], st_clr[ST_SLEEP:ST_BRK]};
		if (brk_hit) begin
			lf_nxt[0] = 1'b1;
			lf_nxt[6:3] = 4'h0;
			sy_wait_nxt = 1'b1;
			idx_nxt = 4'h0;
			sum_nxt = 8'h00;
		end else if (sy_wait_r && fall) begin
			sy_wait_nxt = 1'b0;
			sy_on_nxt = 1'b1;
			sy_fall_nxt = 3'h1;
		end else if (sy_on_r && fall) begin
			sy_fall_nxt = sy_fall_r + 3'h1;
			if (sy_fall_r == SYNC_FALLS - 3'h1) begin
				sy_on_nxt = 1'b0;
				meas_upd = 1'b1;
				lf_nxt[1] = 1'b1;
			end
		end
		if (rx_done && ctrl_r[CTRL_LIN] && !brk_hit && !sy_wait_r) begin
			idx_nxt = (idx_r == 4'hF) ? idx_r : idx_r + 4'h1;
			if (idx_r == 4'h1) begin
				lf_nxt[3] = (rb[6] != p0) || (rb[7] != p1);
				lf_nxt[4] = (rb[5:0] >= ID_RSV);
				lf_nxt[5] = (rb[5:1] == ID_MREQ[5:1]);
				lf_nxt[6] = (rb[5:0] == ID_MREQ);
				sum_nxt = ctrl_r[CTRL_ENH] ? rb : 8'h00;
			end else if (idx_r >= 4'h2) begin
				sum_nxt = sum_c[7:0] + {7'h00, sum_c[8]};
				if ((idx_r == 4'h2 && rb != SLEEP_B0) || (idx_r > 4'h2 && rb != SLEEP_BN))
					lf_nxt[6] = 1'b0;
				if (idx_r == DIAG_LAST && lf_r[6] && !(rb != SLEEP_BN))
					lf_nxt[2] = 1'b1;
			end
		end
	end

	// LIN tracking registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_r <= '0;
			rxd_d_r <= 1'b1;
			sy_wait_r <= 1'b0;
			sy_on_r <= 1'b0;
			sy_cnt_r <= '0;
			sy_fall_r <= 3'h0;
			idx_r <= 4'h0;
			sum_r <= 8'h00;
			lf_r <= 7'h00;
		end else begin
			low_r <= low_nxt;
			rxd_d_r <= rxd;
			sy_wait_r <= sy_wait_nxt;
			sy_on_r <= sy_on_nxt;
			sy_cnt_r <= sy_cnt_nxt;
			sy_fall_r <= sy_fall_nxt;
			idx_r <= idx_nxt;
			sum_r <= sum_nxt;
			lf_r <= lf_nxt;
		end
	end

	chk_break_detect: assert property (brk_hit |=> lf_r[0] && sy_wait_r)
		else $error("break seen but not flagged");
	chk_sync_measure: assert property (meas_upd |=> meas_r == baud_r)
		else $error("measured bit period not applied");

	// ----------------------------------------------------------------
	// register file, address filter and flags
	// ----------------------------------------------------------------
	logic store, is_match;

	assign is_match = ((rx_sh_r[7:0] ^ match_r[7:0]) & match_r[15:8]) == 8'h00;

	// a stored frame and a clearing read in one cycle leave the flag set
	always_comb begin
		ctrl_nxt = ctrl_r;
		baud_nxt = baud_r;
		match_nxt = match_r;
		meas_nxt = meas_r;
		matched_nxt = matched_r;
		rxdata_nxt = rxdata_r;
		store = rx_done;
		if (rx_done && ctrl_r[CTRL_MD] && ctrl_r[CTRL_FILT]) begin
			if (rx_sh_r[8]) begin
				matched_nxt = is_match;
				store = is_match && ctrl_r[CTRL_ACC];
			end else begin
				store = matched_r;
			end
		end
		if (store)
			rxdata_nxt = rx_sh_r;
		rxv_nxt = store | (rxv_r & ~(rd && paddr == OFF_RXDATA));
		coll_nxt = (coll_r & ~st_clr[ST_COLL]) |
			(tx_mid && tx_st_r != TX_IDLE && tx_st_r != TX_WAKE && rxd != txd_r);
		ferr_nxt = (ferr_r & ~st_clr[ST_FERR]) | (rx_done & rx_fe);
		perr_nxt = (perr_r & ~st_clr[ST_PERR]) | (rx_done & par_on_rx & rx_pe_r);
		if (wr && paddr == OFF_CTRL)
			ctrl_nxt = pwdata[CTRL_W-1:0];
		if (wr && paddr == OFF_BAUD)
			baud_nxt = pwdata[15:0];
		if (wr && paddr == OFF_MATCH)
			match_nxt = pwdata[15:0];
		if (meas_upd) begin
			meas_nxt = sy_span[SYNC_SPAN +: 16];
			baud_nxt = sy_span[SYNC_SPAN +: 16];
		end
		prdata_nxt = (psel && !penable && !pwrite) ? rdmux : prdata_r;
	end

	// status word and read mux
	always_comb begin
		status = 32'h0000_0000;
		status[ST_BUSY] = (tx_st_r != TX_IDLE);
		status[ST_RXV] = rxv_r;
		status[ST_COLL] = coll_r;
		status[ST_FERR] = ferr_r;
		status[ST_PERR] = perr_r;
		status[ST_SLEEP:ST_BRK] = lf_r[2:0];
		status[ST_DIAG:ST_PIDE] = lf_r[5:3];
		status[ST_CKOK] = (sum_r == 8'hFF);
		unique case (paddr)
			OFF_CTRL:   rdmux = {22'h000000, ctrl_r};
			OFF_BAUD:   rdmux = {16'h0000, baud_r};
			OFF_MATCH:  rdmux = {16'h0000, match_r};
			OFF_TXDATA: rdmux = {23'h000000, tx_fr_r};
			OFF_RXDATA: rdmux = {23'h000000, rxdata_r};
			OFF_STATUS: rdmux = status;
			OFF_LIN:    rdmux = {meas_r, 4'h0, idx_r, ~sum_r};
			default:    rdmux = 32'h0000_0000;
		endcase
	end

	// register file flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
			baud_r <= BAUD_RST;
			match_r <= MATCH_RST;
			meas_r <= 16'h0000;
			matched_r <= 1'b0;
			rxdata_r <= 9'h000;
			rxv_r <= 1'b0;
			coll_r <= 1'b0;
			ferr_r <= 1'b0;
			perr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			ctrl_r <= ctrl_nxt;
			baud_r <= baud_nxt;
			match_r <= match_nxt;
			meas_r <= meas_nxt;
			matched_r <= matched_nxt;
			rxdata_r <= rxdata_nxt;
			rxv_r <= rxv_nxt;
			coll_r <= coll_nxt;
			ferr_r <= ferr_nxt;
			perr_r <= perr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	sequence seq_data_after_miss;
		rx_done && ctrl_r[CTRL_MD] && ctrl_r[CTRL_FILT] && !rx_sh_r[8] && !matched_r;
	endsequence
	chk_filter_drop: assert property (seq_data_after_miss |=> $stable(rxdata_r))
		else $error("data frame stored after address mismatch");
	chk_addr_accept: assert property ((rx_done && ctrl_r[CTRL_MD] && ctrl_r[CTRL_FILT]
		&& rx_sh_r[8] && is_match && ctrl_r[CTRL_ACC]) |=> rxv_r && rxdata_r[8])
		else $error("accepted address not stored");
	chk_collision_flag: assert property ((tx_mid && tx_st_r == TX_DATA && rxd != txd_r)
		|=> coll_r) else $error("collision not flagged");
endmodule : uml_core
`default_nettype wire

// ==== core/uml_pkg.sv ====
// shared constants for the multidrop / LIN serial extension block
// assumes a 10 MHz APB clock and a 32-bit APB bus with word-aligned registers
package uml_pkg;
	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_BAUD   = 8'h04;
	localparam logic [7:0] OFF_MATCH  = 8'h08;
	localparam logic [7:0] OFF_TXDATA = 8'h0C;
	localparam logic [7:0] OFF_RXDATA = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_LIN    = 8'h18;
	// control field positions
	localparam int CTRL_EN   = 0;
	localparam int CTRL_MD   = 1;   // multidrop_mode
	localparam int CTRL_FILT = 2;   // slave_address_filter_enable
	localparam int CTRL_ACC  = 3;   // accept matched address into receive data
	localparam int CTRL_LIN  = 4;
	localparam int CTRL_ENH  = 5;   // enhanced checksum
	localparam int CTRL_PEN  = 6;
	localparam int CTRL_PODD = 7;
	localparam int CTRL_TX9  = 8;   // transmit_frame_control: nine data bits
	localparam int CTRL_RX9  = 9;   // receive_frame_control: nine data bits
	localparam int CTRL_W    = 10;
	// transmit data command bits
	localparam int TXC_BRK  = 9;
	localparam int TXC_WAKE = 10;
	// status bit positions
	localparam int ST_BUSY = 0, ST_RXV = 1, ST_COLL = 2, ST_FERR = 3, ST_PERR = 4;
	localparam int ST_BRK = 5, ST_SYNC = 6, ST_SLEEP = 7, ST_PIDE = 8, ST_RSV = 9;
	localparam int ST_DIAG = 10, ST_CKOK = 11;
	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST  = 10'h000;
	localparam logic [15:0]       BAUD_RST  = 16'h0208;
	localparam logic [15:0]       MATCH_RST = 16'hFF00;
	// protocol constants
	localparam logic [3:0] BREAK_BITS = 4'hD;
	localparam logic [7:0] SYNC_BYTE  = 8'h55;
	localparam logic [2:0] SYNC_FALLS = 3'h5;
	localparam int         SYNC_SPAN  = 3;    // edges span 2**3 bit periods
	localparam logic [5:0] ID_MREQ    = 6'h3C;
	localparam logic [5:0] ID_SRESP   = 6'h3D;
	localparam logic [5:0] ID_RSV     = 6'h3E;
	localparam logic [7:0] SLEEP_B0   = 8'h00;
	localparam logic [7:0] SLEEP_BN   = 8'hFF;
	localparam logic [3:0] DIAG_LAST  = 4'h9;  // frame index of eighth data byte
	localparam int         CNT_W      = 24;
	// timing
	localparam int CLK_HZ    = 10_000_000;
	localparam int WAKE_US   = 1000;           // inside the 250 us .. 5 ms window
	localparam int WAKE_CYC  = CLK_HZ / 1_000_000 * WAKE_US;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010, TX_PAR = 3'b011,
		TX_STOP = 3'b100, TX_BREAK = 3'b101, TX_DELIM = 3'b110, TX_WAKE = 3'b111
	} uml_tx_e;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_PAR = 3'b011,
		RX_STOP = 3'b100
	} uml_rx_e;
endpackage : uml_pkg

// ==== tb/uml_lin_model.sv ====
// far-side model: a wired-AND serial bus with a pull-up, as an external transceiver
// assumes the block's txd drives the bus and its rxd reads it back
`timescale 1ns/1ns
`default_nettype none
module uml_lin_model (
	// clock
	input  wire logic pclk,
	// bus side
	input  wire logic txd,
	input  wire logic jam,
	output logic      rxd
);
	// ----------------------------------------------------------------
	// bus level
	// ----------------------------------------------------------------
	logic drv_r;
	initial drv_r = 1'b1;
	// dominant low wins, a released bus floats back high
	assign rxd = txd & drv_r & ~jam;
	// drive one level for n cycles, changed just after an edge
	task automatic hold(input logic v, input int n);
		@(posedge pclk);
		drv_r <= v;
		repeat (n - 1) @(posedge pclk);
	endtask : hold
	// one frame: start zero, data lsb first, stop one, then release
	task automatic send(input logic [8:0] d, input int nb, input int baud);
		hold(1'b0, baud);
		for (int i = 0; i < nb; i++) hold(d[i], baud);
		hold(1'b1, baud);
	endtask : send
endmodule : uml_lin_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the multidrop / LIN block, driven over APB
// assumes a 10 MHz pclk and the wired-AND line model on the serial pins
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import uml_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        txd, rxd, jam, last_err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [8:0]  acc;
	int          failures, check_count;
	// address frames and data, with which of them must be kept
	logic [8:0]  fr [0:4] = '{9'h112, 9'h034, 9'h1A3, 9'h077, 9'h1E2};
	logic [4:0]  keep = 5'b10011;
	// ----------------------------------------------------------------
	// design and far side
	// ----------------------------------------------------------------
	uml_core #(.WAKE_CYCLES(20)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .rxd(rxd), .txd(txd));
	uml_lin_model line (.pclk(pclk), .txd(txd), .jam(jam), .rxd(rxd));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask : chk
	// a hung wait counts as a mismatch and ends the run
	task automatic timeout();
		failures++;
		print_verdict();
	endtask : timeout
	// one APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) timeout();
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask : rd
	task automatic wait_idle();
		int k;
		k = 0;
		do begin
			apb(1'b0, OFF_STATUS, 32'h0);
			k++;
		end while (q[ST_BUSY] !== 1'b0 && k < 300);
		if (k >= 300) timeout();
	endtask : wait_idle
	// length of the next low stretch on txd, in cycles
	task automatic count_low(input int e);
		int k, c;
		k = 0;
		c = 0;
		while (txd !== 1'b0 && k < 100) begin
			@(posedge pclk);
			k++;
		end
		while (txd === 1'b0 && c < 1000) begin
			@(posedge pclk);
			c++;
		end
		chk(c, e);
	endtask : count_low
	// time the start bit, then sample each later bit of a frame in its middle
	task automatic sample_tx(input logic [10:0] e, input int baud);
		count_low(baud);
		repeat (baud / 2 - 1) @(posedge pclk);
		for (int i = 1; i < 11; i++) begin
			chk({31'h0, txd}, {31'h0, e[i]});
			repeat (baud) @(posedge pclk);
		end
	endtask : sample_tx
	function automatic logic [7:0] protected_identifier(input logic [5:0] i);
		return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
	endfunction : protected_identifier
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, jam, paddr, pwdata} = '0;
		failures = 0;
		check_count = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_CTRL, 32'hFFFFFFFF, 32'h0);
		rd(OFF_BAUD, 32'hFFFFFFFF, 32'h208);
		rd(OFF_MATCH, 32'hFFFFFFFF, 32'hFF00);
		rd(8'h1C, 32'hFFFFFFFF, 32'h0);
		chk({31'h0, last_err}, 32'h1);
		$display("test reset done");
		// parity asked for, yet multidrop frames must carry none
		apb(1'b1, OFF_BAUD, 32'h8);
		apb(1'b1, OFF_CTRL, 32'h3C3);
		apb(1'b1, OFF_TXDATA, 32'h155);
		sample_tx({1'b1, 9'h155, 1'b0}, 8);
		wait_idle();
		$display("test multidrop send done");
		// masked match: only the low nibble is compared
		apb(1'b1, OFF_MATCH, 32'h0F12);
		apb(1'b1, OFF_CTRL, 32'h30F);
		for (int i = 0; i < 5; i++) begin
			line.send(fr[i], 9, 8);
			repeat (4) @(posedge pclk);
			rd(OFF_STATUS, 32'h2, {30'h0, keep[i], 1'b0});
			if (keep[i]) rd(OFF_RXDATA, 32'h1FF, {23'h0, fr[i]});
		end
		$display("test multidrop filter done");
		apb(1'b1, OFF_BAUD, 32'h10);
		apb(1'b1, OFF_CTRL, 32'h11);
		apb(1'b1, OFF_TXDATA, 32'h400);
		count_low(20);
		wait_idle();
		apb(1'b1, OFF_TXDATA, 32'h200);
		count_low(13 * 16);
		wait_idle();
		apb(1'b1, OFF_TXDATA, {24'h0, SYNC_BYTE});
		wait_idle();
		rd(OFF_LIN, 32'hFFFF0000, 32'h00100000);
		apb(1'b1, OFF_TXDATA, {24'h0, protected_identifier(ID_MREQ)});
		wait_idle();
		// go-to-sleep response with a classic checksum from the far side
		acc = 9'h0;
		for (int i = 0; i < 8; i++) begin
			line.send({1'b0, (i == 0) ? SLEEP_B0 : SLEEP_BN}, 8, 16);
			acc = {1'b0, acc[7:0]} + ((i == 0) ? 9'h0 : 9'h0FF);
			acc = {1'b0, acc[7:0]} + {8'h0, acc[8]};
		end
		line.send({1'b0, ~acc[7:0]}, 8, 16);
		repeat (4) @(posedge pclk);
		rd(OFF_STATUS, 32'hFE0, 32'hCE0);
		$display("test lin header and response done");
		apb(1'b1, OFF_CTRL, 32'h1);
		jam <= 1'b1;
		apb(1'b1, OFF_TXDATA, 32'hFF);
		wait_idle();
		jam <= 1'b0;
		rd(OFF_STATUS, 32'h4, 32'h4);
		apb(1'b1, OFF_STATUS, 32'h4);
		rd(OFF_STATUS, 32'h4, 32'h0);
		$display("test collision done");
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
